// *** verilog/uds_data_status.sv ***
// serial transceiver data byte, line status and multiprocessor status registers
`timescale 1ns/100ps

// Overview of operation
// RULE1: transmit-holding-empty, line status bit 2, is set while holding byte is free.
// RULE2: any write of the transmit data byte clears transmit-holding-empty.
// RULE3: software must not write a transmit byte while holding-empty reads 0.
// RULE4: line status bit 1 is 1 when shifter idle, 0 while transmitting.
// RULE5: line status bit 0 returns the live clear-to-send pin level, uninverted.
// RULE6: software writes zeros to the reserved bits 7:2 of multiproc status.
// RULE7: multiproc status bit 1 flags the held byte as first of a new frame.
// RULE8: reading the receive data byte clears the frame-start flag.
// RULE9: multiproc status bit 0 shows the last received multiprocessor bit.
// RULE10: reading the receive data byte clears the received multiprocessor bit.
// RULE11: each written byte is serialised onto the serial output pin.
// RULE12: transmit and receive data bytes share one address; write loads, read returns.
// RULE13: each received character is stored as a byte in the receive data register.
// RULE14: receive-data-available, status bit 7, set on new byte, cleared by data read.
// RULE15: overrun is flagged when a character completes before the last byte was read.
// RULE16: holding-empty sets again once the held byte moves into the shifter.
module uds_data_status
  import uds_pkg::*;
#(
  parameter int OVS_DIVIDE = uds_pkg::OVS_DIV
)(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  // register file port
  input  wire logic [uds_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [uds_pkg::DATA_W-1:0]   reg_wdata,
  output logic      [uds_pkg::DATA_W-1:0]   reg_rdata,
  // serial pins
  output logic                              serial_out_pin,
  input  wire logic                         serial_in_pin,
  input  wire logic                         cts_n_pin,
  // configuration levels
  input  wire logic                         mp_enable,
  input  wire logic                         tx_multiproc_bit
);
  import uds_pkg::*;

  // oversample divider
  logic [15:0]       div_reg;
  logic              tick_reg;
  // transmit path
  logic [DATA_W-1:0] hold_reg;
  logic              hold_full_reg;
  logic [DATA_W-1:0] tx_shift_reg;
  logic              tx_mpb_reg;
  uds_state_e        tx_state_reg;
  logic [3:0]        tx_tcnt_reg;
  logic [2:0]        tx_bit_reg;
  logic              tx_load;
  // receive path
  logic              char_valid;
  uds_rx_char_s      rx_char;
  logic [DATA_W-1:0] rx_byte_reg;
  logic              avail_reg;
  logic              ovr_reg;
  logic              fe_reg;
  logic              brk_reg;
  logic              frame_start_flag_reg;
  logic              rx_multiproc_bit_reg;
  logic              last_was_addr_reg;
  // register access decode
  logic              data_wr;
  logic              data_rd;
  logic [DATA_W-1:0] line_status;
  logic [DATA_W-1:0] multiproc_status;
  logic              tx_holding_empty;
  logic              tx_shift_idle;

  assign data_wr          = reg_wr && (reg_addr == DATA_OFS); // [RULE12]
  assign data_rd          = reg_rd && (reg_addr == DATA_OFS); // [RULE12]
  assign tx_holding_empty = !hold_full_reg;                   // [RULE1]
  // idle only when nothing is shifting and nothing waits to shift
  assign tx_shift_idle    = (tx_state_reg == UDS_IDLE) && !hold_full_reg; // [RULE4]
  assign tx_load          = hold_full_reg && (tx_state_reg == UDS_IDLE);

  always_comb begin
    line_status            = ZERO_BYTE;
    line_status[LS_AVAIL]  = avail_reg;         // [RULE14]
    line_status[LS_PE]     = 1'b0;
    line_status[LS_OE]     = ovr_reg;           // [RULE15]
    line_status[LS_FE]     = fe_reg;
    line_status[LS_BRK]    = brk_reg;
    line_status[LS_THRE]   = tx_holding_empty;  // [RULE1]
    line_status[LS_TXIDLE] = tx_shift_idle;     // [RULE4]
    line_status[LS_CTS]    = cts_n_pin;         // [RULE5]
  end

  always_comb begin
    multiproc_status           = ZERO_BYTE;
    multiproc_status[MP_FRAME] = frame_start_flag_reg; // [RULE7]
    multiproc_status[MP_BIT]   = rx_multiproc_bit_reg; // [RULE9]
  end

  // one-cycle tick at sixteen times the bit rate
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (div_reg == 16'(OVS_DIVIDE - 1)) begin
      div_reg  <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // read data registered; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= ZERO_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        DATA_OFS:   reg_rdata <= rx_byte_reg;       // [RULE12]
        LSTAT_OFS:  reg_rdata <= line_status;       // [RULE5]
        MPSTAT_OFS: reg_rdata <= multiproc_status;
        default:    reg_rdata <= ZERO_BYTE;
      endcase
    end
  end

  // holding register; a write in the transfer cycle keeps it full
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_reg      <= ZERO_BYTE;
      hold_full_reg <= 1'b0;
    end else if (data_wr) begin
      hold_reg      <= reg_wdata;
      hold_full_reg <= 1'b1;      // [RULE2]
    end else if (tx_load) begin
      hold_full_reg <= 1'b0;      // [RULE16]
    end
  end

  // transmit shifter, lsb first, each bit sixteen ticks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_state_reg   <= UDS_IDLE;
      tx_shift_reg   <= ZERO_BYTE;
      tx_mpb_reg     <= 1'b0;
      tx_tcnt_reg    <= OVS_ZERO;
      tx_bit_reg     <= BIT_ZERO;
      serial_out_pin <= 1'b1;
    end else begin
      case (tx_state_reg)
        UDS_IDLE: begin
          serial_out_pin <= 1'b1;
          if (tx_load) begin
            tx_shift_reg   <= hold_reg;       // [RULE11]
            tx_mpb_reg     <= tx_multiproc_bit;
            tx_tcnt_reg    <= OVS_ZERO;
            tx_bit_reg     <= BIT_ZERO;
            serial_out_pin <= 1'b0;
            tx_state_reg   <= UDS_START;
          end
        end
        UDS_START, UDS_DATA, UDS_MPB, UDS_STOP: begin
          if (tick_reg) begin
            tx_tcnt_reg <= tx_tcnt_reg + 4'h1;
            if (tx_tcnt_reg == OVS_LAST) begin
              case (tx_state_reg)
                UDS_START: begin
                  serial_out_pin <= tx_shift_reg[0]; // [RULE11]
                  tx_state_reg   <= UDS_DATA;
                end
                UDS_DATA: begin
                  tx_bit_reg <= tx_bit_reg + 3'h1;
                  if (tx_bit_reg == BIT_LAST) begin
                    serial_out_pin <= mp_enable ? tx_mpb_reg : 1'b1;
                    tx_state_reg   <= mp_enable ? UDS_MPB : UDS_STOP;
                  end else begin
                    tx_shift_reg   <= {1'b0, tx_shift_reg[DATA_W-1:1]};
                    serial_out_pin <= tx_shift_reg[1];
                  end
                end
                UDS_MPB: begin
                  serial_out_pin <= 1'b1;
                  tx_state_reg   <= UDS_STOP;
                end
                default: begin
                  serial_out_pin <= 1'b1;
                  tx_state_reg   <= UDS_IDLE;
                end
              endcase
            end
          end
        end
        default: tx_state_reg <= UDS_IDLE;
      endcase
    end
  end

  uds_rx_deser uds_rx_deser_inst (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .ovs_tick      (tick_reg),
    .serial_in_pin (serial_in_pin),
    .mp_enable     (mp_enable),
    .char_valid    (char_valid),
    .char_out      (rx_char)
  );

  // receive byte register; undefined before the first character
  always_ff @(posedge clk) begin
    if (char_valid) rx_byte_reg <= rx_char.data; // [RULE13]
  end

  // status flags: a new character wins over a clearing read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avail_reg <= 1'b0;
      ovr_reg   <= 1'b0;
      fe_reg    <= 1'b0;
      brk_reg   <= 1'b0;
    end else if (char_valid) begin
      avail_reg <= 1'b1;                            // [RULE14]
      ovr_reg   <= ovr_reg || (avail_reg && !data_rd); // [RULE15]
      fe_reg    <= rx_char.frame_err;
      brk_reg   <= rx_char.brk;
    end else if (data_rd) begin
      avail_reg <= 1'b0;                            // [RULE14]
      ovr_reg <= 1'b0;
      fe_reg  <= 1'b0;
      brk_reg <= 1'b0;
    end
  end

  // multiprocessor flags; an address character opens a frame
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frame_start_flag_reg <= 1'b0;
      rx_multiproc_bit_reg <= 1'b0;
      last_was_addr_reg    <= 1'b0;
    end else if (char_valid) begin
      rx_multiproc_bit_reg <= rx_char.mpb;      // [RULE9]
      frame_start_flag_reg <= mp_enable && !rx_char.mpb && last_was_addr_reg; // [RULE7]
      last_was_addr_reg    <= mp_enable && rx_char.mpb;
    end else if (data_rd) begin
      frame_start_flag_reg <= 1'b0;             // [RULE8]
      rx_multiproc_bit_reg <= 1'b0;             // [RULE10]
    end
  end

  sequence s_data_write;
    data_wr;
  endsequence

  sequence s_clean_read;
    data_rd && !char_valid;
  endsequence

  sequence s_start_bit;
    !serial_out_pin [*8];
  endsequence

  a_thre_write_clear: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
    s_data_write |=> !line_status[LS_THRE] && hold_reg == $past(reg_wdata))
    else $error("holding-empty not cleared by write");

  a_thre_refill_set: assert property (@(posedge clk) disable iff (sys_rst) // [RULE16]
    (tx_load && !data_wr) |=> tx_holding_empty && tx_state_reg == UDS_START)
    else $error("holding-empty not set after transfer");

  a_tx_start_bit: assert property (@(posedge clk) disable iff (sys_rst) // [RULE11]
    tx_load |=> s_start_bit)
    else $error("start bit missing after load");

  a_txidle_busy: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
    (tx_state_reg != UDS_IDLE || !serial_out_pin) |-> !line_status[LS_TXIDLE])
    else $error("idle flag set while shifting");

  a_cts_live_read: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
    (reg_rd && reg_addr == LSTAT_OFS) |=> reg_rdata[LS_CTS] == $past(cts_n_pin))
    else $error("cts bit does not follow pin");

  a_rx_byte_store: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
    char_valid |=> rx_byte_reg == $past(rx_char.data) && avail_reg)
    else $error("received byte not stored");

  a_avail_read_clr: assert property (@(posedge clk) disable iff (sys_rst) // [RULE14]
    s_clean_read |=> !avail_reg ##1 (!avail_reg || $past(char_valid)))
    else $error("data available not cleared by read");

  a_overrun_flag: assert property (@(posedge clk) disable iff (sys_rst) // [RULE15]
    (char_valid && avail_reg && !data_rd) |=> ovr_reg)
    else $error("overrun not flagged");

  a_frame_read_clr: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
    s_clean_read |=> !multiproc_status[MP_FRAME])
    else $error("frame-start not cleared by read");

  a_mpbit_read_clr: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
    s_clean_read |=> !multiproc_status[MP_BIT])
    else $error("multiproc bit not cleared by read");

  a_mpbit_capture: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
    char_valid |=> rx_multiproc_bit_reg == $past(rx_char.mpb))
    else $error("multiproc bit not captured");

endmodule // uds_data_status

// *** verilog/uds_pkg.sv ***
// shared constants and types for the serial data and status registers
package uds_pkg;

  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 8;
  localparam int CLK_HZ    = 125_000_000;
  localparam int BAUD_BPS  = 115_200;
  localparam int OVS_RATE  = 16;
  localparam int OVS_DIV   = CLK_HZ / (OVS_RATE * BAUD_BPS);

  localparam logic [ADDR_W-1:0] DATA_OFS   = 12'hF40;
  localparam logic [ADDR_W-1:0] LSTAT_OFS  = 12'hF41;
  localparam logic [ADDR_W-1:0] MPSTAT_OFS = 12'hF44;

  // line_status field positions
  localparam int LS_AVAIL  = 7;
  localparam int LS_PE     = 6;
  localparam int LS_OE     = 5;
  localparam int LS_FE     = 4;
  localparam int LS_BRK    = 3;
  localparam int LS_THRE   = 2;
  localparam int LS_TXIDLE = 1;
  localparam int LS_CTS    = 0;

  // multiproc_status field positions
  localparam int MP_FRAME  = 1;
  localparam int MP_BIT    = 0;

  localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
  localparam logic [3:0]        OVS_LAST   = 4'hF;
  localparam logic [3:0]        OVS_MID    = 4'h7;
  localparam logic [3:0]        OVS_ZERO   = 4'h0;
  localparam logic [2:0]        BIT_LAST   = 3'h7;
  localparam logic [2:0]        BIT_ZERO   = 3'h0;

  typedef enum logic [4:0] {
    UDS_IDLE  = 5'h01,
    UDS_START = 5'h02,
    UDS_DATA  = 5'h04,
    UDS_MPB   = 5'h08,
    UDS_STOP  = 5'h10
  } uds_state_e;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              mpb;
    logic              frame_err;
    logic              brk;
  } uds_rx_char_s;

endpackage

// *** verilog/uds_rx_deser.sv ***
// receive deserialiser: start, eight data bits, optional multiproc bit, stop
`timescale 1ns/100ps
module uds_rx_deser
  import uds_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // line side
  input  wire logic                  ovs_tick,
  input  wire logic                  serial_in_pin,
  input  wire logic                  mp_enable,
  // character out
  output logic                       char_valid,
  output uds_pkg::uds_rx_char_s      char_out
);
  import uds_pkg::*;

  uds_state_e        state_reg;
  logic [3:0]        tcnt_reg;
  logic [2:0]        bit_reg;
  logic [DATA_W-1:0] shift_reg;
  logic              mpb_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg  <= UDS_IDLE;
      tcnt_reg   <= OVS_ZERO;
      bit_reg    <= BIT_ZERO;
      shift_reg  <= ZERO_BYTE;
      mpb_reg    <= 1'b0;
      char_valid <= 1'b0;
      char_out   <= '0;
    end else begin
      char_valid <= 1'b0;
      if (ovs_tick) begin
        tcnt_reg <= tcnt_reg + 4'h1;
        case (state_reg)
          UDS_IDLE: begin
            tcnt_reg <= OVS_ZERO;
            if (!serial_in_pin) state_reg <= UDS_START;
          end
          UDS_START: begin
            // confirm start at mid bit so glitches are dropped
            if (tcnt_reg == OVS_MID) begin
              tcnt_reg  <= OVS_ZERO;
              bit_reg   <= BIT_ZERO;
              state_reg <= serial_in_pin ? UDS_IDLE : UDS_DATA;
            end
          end
          UDS_DATA: begin
            if (tcnt_reg == OVS_LAST) begin
              shift_reg <= {serial_in_pin, shift_reg[DATA_W-1:1]};
              bit_reg   <= bit_reg + 3'h1;
              mpb_reg   <= 1'b0;
              if (bit_reg == BIT_LAST) state_reg <= mp_enable ? UDS_MPB : UDS_STOP;
            end
          end
          UDS_MPB: begin
            if (tcnt_reg == OVS_LAST) begin
              mpb_reg   <= serial_in_pin;
              state_reg <= UDS_STOP;
            end
          end
          UDS_STOP: begin
            if (tcnt_reg == OVS_LAST) begin
              char_valid         <= 1'b1;
              char_out.data      <= shift_reg;
              char_out.mpb       <= mpb_reg;
              char_out.frame_err <= !serial_in_pin;
              char_out.brk       <= !serial_in_pin && !mpb_reg && (shift_reg == ZERO_BYTE);
              state_reg          <= UDS_IDLE;
            end
          end
          default: state_reg <= UDS_IDLE;
        endcase
      end
    end
  end

endmodule // uds_rx_deser

// *** testbench/uds_remote_node.sv ***
// remote serial node model: frame sender and frame collector on the pins
`timescale 1ns/100ps
module uds_remote_node
  import uds_pkg::*;
#(
  parameter int BIT_CYC = 16
)(
  // clock
  input  wire logic  clk,
  // serial lines, named from the device side
  input  wire logic  serial_out_pin,
  output logic       serial_in_pin,
  // frame format
  input  wire logic  mp_enable
);
  import uds_pkg::*;

  // frames seen, as {stop, mp bit, data}
  logic [9:0] got_q[$];

  initial begin
    serial_in_pin = 1'b1;
  end

  // sampled at mid bit so edge placement within a tick does not matter
  always begin : rx_proc
    logic [9:0] bits;
    int         n;
    @(negedge serial_out_pin);
    repeat (BIT_CYC / 2) @(posedge clk);
    bits = '0;
    n = mp_enable ? 10 : 9;
    for (int i = 0; i < n; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      bits = {serial_out_pin, bits[9:1]};
    end
    if (!mp_enable) begin
      bits = {bits[9], 1'b0, bits[8:1]};
    end
    got_q.push_back(bits);
  end

  task automatic send_char(input logic [DATA_W-1:0] d, input logic mpb);
    logic [10:0] frame;
    int          n;
    frame = mp_enable ? {1'b1, mpb, d, 1'b0} : {2'b11, d, 1'b0};
    n = mp_enable ? 11 : 10;
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      #1;
      serial_in_pin = frame[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask
endmodule // uds_remote_node

// *** testbench/uds_data_status_tb.sv ***
// self-checking bench for the serial data and status registers
`timescale 1ns/100ps
module uds_data_status_tb;
  import uds_pkg::*;

  logic              clk;
  logic              sys_rst;
  logic [ADDR_W-1:0] reg_addr;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic              serial_out_pin;
  logic              serial_in_pin;
  logic              cts_n_pin;
  logic              mp_enable;
  logic              tx_multiproc_bit;
  int                n_fail;
  int                compares;
  int                cycles;

  uds_data_status #(.OVS_DIVIDE(1)) uds_data_status_inst (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .reg_addr         (reg_addr),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_wdata        (reg_wdata),
    .reg_rdata        (reg_rdata),
    .serial_out_pin   (serial_out_pin),
    .serial_in_pin    (serial_in_pin),
    .cts_n_pin        (cts_n_pin),
    .mp_enable        (mp_enable),
    .tx_multiproc_bit (tx_multiproc_bit)
  );

  uds_remote_node #(.BIT_CYC(16)) uds_remote_node_inst (
    .clk            (clk),
    .serial_out_pin (serial_out_pin),
    .serial_in_pin  (serial_in_pin),
    .mp_enable      (mp_enable)
  );

  always #4 clk = ~clk;

  task automatic finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // a whole run needs about two thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      $display("timeout after %0d cycles", cycles);
      finish_test;
    end
  end

  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                        input string what);
    logic [DATA_W-1:0] d;
    rd(a, d);
    check(what, {2'b00, d}, {2'b00, exp});
  endtask

  // polls status only, which has no read side effect
  task automatic wait_avail;
    logic [DATA_W-1:0] s;
    int                k;
    k = 0;
    do begin
      rd(LSTAT_OFS, s);
      k++;
    end while (s[LS_AVAIL] !== 1'b1 && k < 400);
  endtask

  initial begin
    logic [9:0] f;
    int         k;
    clk = 1'b0;
    sys_rst = 1'b1;
    reg_addr = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = '0;
    cts_n_pin = 1'b1;
    mp_enable = 1'b0;
    tx_multiproc_bit = 1'b0;
    n_fail = 0;
    compares = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;

    rd_chk(LSTAT_OFS, 8'h07, "line_status reset");
    cts_n_pin = 1'b0;
    rd_chk(LSTAT_OFS, 8'h06, "line_status cts low");
    cts_n_pin = 1'b1;
    rd_chk(MPSTAT_OFS, 8'h00, "multiproc_status reset");
    rd_chk(12'hF42, 8'h00, "unmapped read");
    wr(LSTAT_OFS, 8'hFF);
    rd_chk(LSTAT_OFS, 8'h07, "line_status after write");
    $display("test reset_status done");

    for (int m = 0; m < 2; m++) begin
      mp_enable = m[0];
      tx_multiproc_bit = m[0];
      wr(DATA_OFS, 8'hA5);
      repeat (3) @(posedge clk);
      rd_chk(LSTAT_OFS, 8'h05, "holding free, shifting");
      wr(DATA_OFS, 8'h3C);
      rd_chk(LSTAT_OFS, 8'h01, "holding full");
      k = 0;
      while (uds_remote_node_inst.got_q.size() < 2 && k < 1000) begin
        @(posedge clk);
        k++;
      end
      f = (uds_remote_node_inst.got_q.size() > 0) ? uds_remote_node_inst.got_q.pop_front() : 'x;
      check("tx frame one", f, {1'b1, m[0], 8'hA5});
      f = (uds_remote_node_inst.got_q.size() > 0) ? uds_remote_node_inst.got_q.pop_front() : 'x;
      check("tx frame two", f, {1'b1, m[0], 8'h3C});
      repeat (20) @(posedge clk);
      rd_chk(LSTAT_OFS, 8'h07, "transmit finished");
    end
    mp_enable = 1'b0;
    $display("test transmit done");

    uds_remote_node_inst.send_char(8'h5A, 1'b0);
    wait_avail;
    rd_chk(LSTAT_OFS, 8'h87, "byte waiting");
    rd_chk(DATA_OFS, 8'h5A, "rx byte");
    rd_chk(LSTAT_OFS, 8'h07, "byte taken");
    uds_remote_node_inst.send_char(8'h96, 1'b0);
    uds_remote_node_inst.send_char(8'hC3, 1'b0);
    repeat (4) @(posedge clk);
    rd_chk(LSTAT_OFS, 8'hA7, "overrun");
    rd_chk(DATA_OFS, 8'hC3, "rx newest byte");
    rd_chk(LSTAT_OFS, 8'h07, "overrun cleared");
    $display("test receive done");

    mp_enable = 1'b1;
    uds_remote_node_inst.send_char(8'h11, 1'b1);
    wait_avail;
    rd_chk(MPSTAT_OFS, 8'h01, "address char");
    rd_chk(DATA_OFS, 8'h11, "address byte");
    rd_chk(MPSTAT_OFS, 8'h00, "mp bit cleared");
    uds_remote_node_inst.send_char(8'h22, 1'b0);
    wait_avail;
    rd_chk(MPSTAT_OFS, 8'h02, "first data of frame");
    wr(MPSTAT_OFS, 8'h00);
    rd_chk(MPSTAT_OFS, 8'h02, "status kept");
    rd_chk(DATA_OFS, 8'h22, "first data byte");
    rd_chk(MPSTAT_OFS, 8'h00, "frame flag cleared");
    uds_remote_node_inst.send_char(8'h33, 1'b0);
    wait_avail;
    rd_chk(MPSTAT_OFS, 8'h00, "later data of frame");
    rd_chk(DATA_OFS, 8'h33, "later data byte");
    mp_enable = 1'b0;
    $display("test multiproc done");
    finish_test;
  end
endmodule // uds_data_status_tb
